// file: hdl/charge_cycle_sequencer.sv
// Purpose: Control sequencer of a single-cell CC/CV charger
// Assumes: Comparator results arrive asynchronous; one 125 MHz clock
// Notes: Analog thresholds and current programming live outside
`include "charge_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module charge_cycle_sequencer #(
	parameter int TICK_CYCLES = `CCS_SECOND_NS / `CCS_CLOCK_PERIOD_NS
)
(
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic CE,
	// Battery and current comparators
	input wire logic VBAT_AT_CV,
	input wire logic VBAT_BELOW_RECHARGE,
	input wire logic VBAT_BELOW_PRECHARGE,
	input wire logic IOUT_BELOW_TERM,
	// Thermistor comparators, trip and release levels
	input wire logic NTC_BELOW_HOT_TRIP,
	input wire logic NTC_BELOW_HOT_RELEASE,
	input wire logic NTC_ABOVE_COLD_DEF_TRIP,
	input wire logic NTC_ABOVE_COLD_DEF_RELEASE,
	input wire logic NTC_ABOVE_COLD_CTO_TRIP,
	input wire logic NTC_ABOVE_COLD_CTO_RELEASE,
	input wire logic COLD_OFFSET_GROUNDED,
	input wire logic NTC_BELOW_DISABLE,
	// Timer select pin decoding and programmed duration
	input wire logic TIMER_SELECT_HIGH,
	input wire logic TIMER_SELECT_GROUNDED,
	input wire logic [15:0] TIMER_PROG_MINUTES,
	// Outputs
	output logic OUTPUT_ENABLE,
	output logic CHARGE_ACTIVE_FLAG_N,
	output logic FAULT_FLAG_N,
	output logic TIMER_EXPIRED
);

	// ********************************************************
	// Elaboration checks and local functions
	// ********************************************************

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	// Refuse a tick length that the counter cannot serve
	if (TICK_CYCLES < 1)
	begin : g_tick_check
		$error("TICK_CYCLES must be at least one");
	end

	// Timer limit in seconds from the selected duration in minutes
	function automatic charge_pkg::sec_t minutes_to_sec(
		input logic [15:0] minutes);
		logic [15:0] m;
		m = minutes;
		if (m < `CCS_PROG_MIN_LO)
			m = `CCS_PROG_MIN_LO;
		if (m > `CCS_PROG_MIN_HI)
			m = `CCS_PROG_MIN_HI;
		return 16'(m * `CCS_SEC_PER_MIN);
	endfunction

	// ********************************************************
	// Input synchronisers
	// ********************************************************

	logic [`CCS_IN_W-1:0] raw_in;
	logic [`CCS_IN_W-1:0] sync1_r;
	logic [`CCS_IN_W-1:0] sync2_r;
	logic [15:0] prog1_r;
	logic [15:0] prog2_r;

	assign raw_in = {TIMER_SELECT_GROUNDED, TIMER_SELECT_HIGH,
		NTC_BELOW_DISABLE, COLD_OFFSET_GROUNDED,
		NTC_ABOVE_COLD_CTO_RELEASE, NTC_ABOVE_COLD_CTO_TRIP,
		NTC_ABOVE_COLD_DEF_RELEASE, NTC_ABOVE_COLD_DEF_TRIP,
		NTC_BELOW_HOT_RELEASE, NTC_BELOW_HOT_TRIP,
		IOUT_BELOW_TERM, VBAT_BELOW_PRECHARGE,
		VBAT_BELOW_RECHARGE, VBAT_AT_CV};

	// Two stages before any logic; the duration word is quasi-static
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prog1_r <= '0;
			prog2_r <= '0;
		end
		else if (CE)
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
			prog1_r <= TIMER_PROG_MINUTES;
			prog2_r <= prog1_r;
		end
	end

	logic at_cv;
	logic below_rechg;
	logic below_pre;
	logic below_term;
	logic ntc_dis;
	logic cold_trip;
	logic cold_rel;

	assign at_cv = sync2_r[`CCS_IN_CV];
	assign below_rechg = sync2_r[`CCS_IN_RECHG];
	assign below_pre = sync2_r[`CCS_IN_PRE];
	assign below_term = sync2_r[`CCS_IN_TERM];
	assign ntc_dis = sync2_r[`CCS_IN_NTC_DIS];

	// Cold comparator pair picked by the offset pin
	assign cold_trip = sync2_r[`CCS_IN_CTO_GND] ?
		sync2_r[`CCS_IN_COLD_DEF_TRIP] :
		sync2_r[`CCS_IN_COLD_CTO_TRIP];
	assign cold_rel = sync2_r[`CCS_IN_CTO_GND] ?
		sync2_r[`CCS_IN_COLD_DEF_REL] :
		sync2_r[`CCS_IN_COLD_CTO_REL];

	// ********************************************************
	// Temperature suspend with hysteresis
	// ********************************************************

	logic hot_r;
	logic cold_r;
	logic suspend;

	// Set at the trip level, cleared only past the release level, so
	// a slow thermistor cannot chatter; disable clears both flags
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			hot_r <= 1'b0;
			cold_r <= 1'b0;
		end
		else if (CE)
		begin
			if (sync2_r[`CCS_IN_HOT_TRIP] && !ntc_dis)
				hot_r <= 1'b1;
			else if (!sync2_r[`CCS_IN_HOT_REL] || ntc_dis)
				hot_r <= 1'b0;
			if (cold_trip && !ntc_dis)
				cold_r <= 1'b1;
			else if (!cold_rel || ntc_dis)
				cold_r <= 1'b0;
		end
	end

	// Disable level takes precedence over a hot reading
	assign suspend = (hot_r | cold_r) & ~ntc_dis;

	// ********************************************************
	// Timer mode and limit
	// ********************************************************

	logic timer_on;
	charge_pkg::sec_t limit_sec;
	charge_pkg::sec_t pre_limit_sec;

	// Tied low disables; tied high is default; otherwise resistor
	assign timer_on = ~sync2_r[`CCS_IN_TSEL_GND];
	assign limit_sec = sync2_r[`CCS_IN_TSEL_HI] ?
		minutes_to_sec(`CCS_DEFAULT_MIN) :
		minutes_to_sec(prog2_r);
	assign pre_limit_sec = limit_sec >> `CCS_PRE_SHIFT;

	// ********************************************************
	// Charge sequence
	// ********************************************************

	charge_pkg::state_e state_r;
	charge_pkg::state_e state_nxt;
	charge_pkg::sec_t elapsed_r;
	charge_pkg::sec_t pre_elapsed_r;
	logic [TICK_W-1:0] tick_cnt_r;
	logic expired;
	logic pre_over;
	logic charging;
	logic restart;

	assign charging = (state_r == charge_pkg::ST_PRE) ||
		(state_r == charge_pkg::ST_CC) ||
		(state_r == charge_pkg::ST_CV) ||
		(state_r == charge_pkg::ST_FLOAT);
	assign expired = timer_on && (elapsed_r >= limit_sec);
	assign pre_over = timer_on && (pre_elapsed_r >= pre_limit_sec);
	assign restart = (state_r == charge_pkg::ST_MONITOR) && below_rechg;

	// Next state; suspend freezes the four charging states where they stand
	always_comb
	begin
		state_nxt = state_r;
		if (ntc_dis)
			state_nxt = charge_pkg::ST_IDLE;
		else if (suspend && charging)
			state_nxt = state_r;
		else if (charging && expired)
			state_nxt = charge_pkg::ST_MONITOR;
		else
		begin
			unique case (state_r)
				charge_pkg::ST_IDLE:
					state_nxt = below_pre ? charge_pkg::ST_PRE :
						charge_pkg::ST_CC;
				charge_pkg::ST_PRE:
					if (pre_over)
						state_nxt = charge_pkg::ST_PRE_FAULT;
					else if (!below_pre)
						state_nxt = charge_pkg::ST_CC;
				charge_pkg::ST_CC:
					if (at_cv)
						state_nxt = charge_pkg::ST_CV;
				charge_pkg::ST_CV:
					if (below_term)
						state_nxt = timer_on ? charge_pkg::ST_FLOAT :
							charge_pkg::ST_MONITOR;
				charge_pkg::ST_FLOAT:
					state_nxt = charge_pkg::ST_FLOAT;
				charge_pkg::ST_MONITOR:
					if (below_rechg)
						state_nxt = charge_pkg::ST_IDLE;
				charge_pkg::ST_PRE_FAULT:
					if (!below_pre)
						state_nxt = charge_pkg::ST_CC;
				default:
					state_nxt = charge_pkg::ST_IDLE;
			endcase
		end
	end

	// State register; power-on reset lands in idle
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			state_r <= charge_pkg::ST_IDLE;
		else if (CE)
			state_r <= state_nxt;
	end

	// One-second tick runs only while the output is on
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			tick_cnt_r <= '0;
		else if (CE)
		begin
			if (ntc_dis || restart || !charging || suspend)
				tick_cnt_r <= '0;
			else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1))
				tick_cnt_r <= '0;
			else
				tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	// Elapsed on-time; paused, not cleared, while suspended
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			elapsed_r <= '0;
			pre_elapsed_r <= '0;
		end
		else if (CE)
		begin
			if (ntc_dis || restart)
			begin
				elapsed_r <= '0;
				pre_elapsed_r <= '0;
			end
			else if (charging && !suspend &&
				tick_cnt_r == TICK_W'(TICK_CYCLES - 1))
			begin
				if (!expired)
					elapsed_r <= elapsed_r + 1'b1;
				if (state_r == charge_pkg::ST_PRE && !pre_over)
					pre_elapsed_r <= pre_elapsed_r + 1'b1;
			end
		end
	end

	// ********************************************************
	// Output flags, all registered
	// ********************************************************

	// Output on only while charging, unsuspended and in time
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			OUTPUT_ENABLE <= 1'b0;
			CHARGE_ACTIVE_FLAG_N <= 1'b1;
			FAULT_FLAG_N <= 1'b1;
			TIMER_EXPIRED <= 1'b0;
		end
		else if (CE)
		begin
			OUTPUT_ENABLE <= charging && !suspend && !expired &&
				!ntc_dis;
			// Charge-active drops once termination current is seen
			CHARGE_ACTIVE_FLAG_N <= !(state_r == charge_pkg::ST_PRE ||
				state_r == charge_pkg::ST_CC ||
				state_r == charge_pkg::ST_CV) || ntc_dis;
			// Disable masks a stale precharge fault in the same cycle
			FAULT_FLAG_N <= !(suspend || state_r ==
				charge_pkg::ST_PRE_FAULT) || ntc_dis;
			TIMER_EXPIRED <= expired;
		end
	end

endmodule // charge_cycle_sequencer

`default_nettype wire

// file: hdl/charge_consts.svh
// Purpose: Constants of the charge cycle sequencer
// Assumes: Included by bare name where needed
// Notes: Times in their own units; cycle counts derived in the module
`ifndef CHARGE_CONSTS_SVH
`define CHARGE_CONSTS_SVH
// Clock period and the one-second timer tick
`define CCS_CLOCK_PERIOD_NS 8
`define CCS_SECOND_NS 1000000000
// Charge timer durations in minutes
`define CCS_DEFAULT_MIN 16'd180
`define CCS_PROG_MIN_LO 16'd120
`define CCS_PROG_MIN_HI 16'd360
`define CCS_SEC_PER_MIN 16'd60
// Precharge may use one quarter (25%) of the total charge time
`define CCS_PRE_SHIFT 2
// Disable level on the thermistor pin, in millivolts (comparator outside)
`define CCS_NTC_DISABLE_MV 600
// Synchronised input vector layout
`define CCS_IN_CV 0
`define CCS_IN_RECHG 1
`define CCS_IN_PRE 2
`define CCS_IN_TERM 3
`define CCS_IN_HOT_TRIP 4
`define CCS_IN_HOT_REL 5
`define CCS_IN_COLD_DEF_TRIP 6
`define CCS_IN_COLD_DEF_REL 7
`define CCS_IN_COLD_CTO_TRIP 8
`define CCS_IN_COLD_CTO_REL 9
`define CCS_IN_CTO_GND 10
`define CCS_IN_NTC_DIS 11
`define CCS_IN_TSEL_HI 12
`define CCS_IN_TSEL_GND 13
`define CCS_IN_W 14
`endif

// file: hdl/charge_pkg.sv
// Purpose: Types of the charge cycle sequencer
// Assumes: Nothing beyond the constants header
// Notes: States are one-hot
package charge_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_PRE = 7'h02,
		ST_CC = 7'h04,
		ST_CV = 7'h08,
		ST_FLOAT = 7'h10,
		ST_MONITOR = 7'h20,
		ST_PRE_FAULT = 7'h40
	} state_e;
	typedef logic [15:0] sec_t;
endpackage

// file: sim/ccs_checker.sv
// Purpose: Port assertions for the charge cycle sequencer
// Assumes: Inputs reach the outputs three or four clock edges later
// Notes: Held inputs use six cycles so the sync chain has settled
`timescale 1ns/1ps
`default_nettype none
module ccs_checker (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic CE,
	// Comparator and select inputs
	input wire logic NTC_BELOW_DISABLE,
	input wire logic NTC_BELOW_HOT_TRIP,
	input wire logic COLD_OFFSET_GROUNDED,
	input wire logic NTC_ABOVE_COLD_DEF_TRIP,
	input wire logic NTC_ABOVE_COLD_CTO_TRIP,
	input wire logic TIMER_SELECT_GROUNDED,
	// Outputs
	input wire logic OUTPUT_ENABLE,
	input wire logic FAULT_FLAG_N,
	input wire logic TIMER_EXPIRED
);
	// ****************
	// Port properties
	// ****************
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// Output drops with a fault shown: start of a temperature pause or of a precharge fault
	sequence s_pause_start;
		$fell(OUTPUT_ENABLE) && !FAULT_FLAG_N;
	endsequence
	a_disable_stops: assert property ((CE && NTC_BELOW_DISABLE) [*6] |-> !OUTPUT_ENABLE && FAULT_FLAG_N)
		else $error("charging or fault flag while disabled");
	a_hot_suspend: assert property ((CE && !NTC_BELOW_DISABLE && NTC_BELOW_HOT_TRIP) [*6] |-> !OUTPUT_ENABLE && !FAULT_FLAG_N)
		else $error("hot battery not suspended");
	a_cold_default: assert property ((CE && !NTC_BELOW_DISABLE && COLD_OFFSET_GROUNDED && NTC_ABOVE_COLD_DEF_TRIP) [*6] |-> !OUTPUT_ENABLE && !FAULT_FLAG_N)
		else $error("default cold level not obeyed");
	a_cold_offset: assert property ((CE && !NTC_BELOW_DISABLE && !COLD_OFFSET_GROUNDED && NTC_ABOVE_COLD_CTO_TRIP) [*6] |-> !OUTPUT_ENABLE && !FAULT_FLAG_N)
		else $error("offset cold level not obeyed");
	a_no_timer: assert property ((CE && TIMER_SELECT_GROUNDED) [*6] |-> !TIMER_EXPIRED)
		else $error("expiry with timer disabled");
	a_expiry_off: assert property (TIMER_EXPIRED |-> ##[0:2] !OUTPUT_ENABLE)
		else $error("output still on after expiry");
	a_on_no_fault: assert property (OUTPUT_ENABLE |-> FAULT_FLAG_N)
		else $error("output on while fault shown");
	a_pause_holds: assert property (s_pause_start ##1 !FAULT_FLAG_N |-> $stable(TIMER_EXPIRED))
		else $error("timer moved during pause");
endmodule // ccs_checker
bind charge_cycle_sequencer ccs_checker u_ccs_checker (.*);
`default_nettype wire

// file: sim/battery_pack_model.sv
// Purpose: Comparators, thermistor and timer pin in front of the sequencer
// Assumes: Levels in millivolts and milliamps, supply of 5 V
// Notes: Bit order of cmp matches the sequencer's input vector
`timescale 1ns/1ps
`default_nettype none
module battery_pack_model #(
	parameter int CV_MV = 4200,
	parameter int RECHG_MV = 4100,
	parameter int PRE_MV = 2800,
	parameter int TERM_MA = 100,
	parameter int HOT_MV = 1500,
	parameter int COLD_MV = 3700,
	parameter int HYST_MV = 100,
	parameter int DIS_MV = 600
)
(
	// Analog levels
	input var int vbat_mv,
	input var int iout_ma,
	input var int ntc_mv,
	input var int cto_mv,
	input var int tsel,
	// Comparator results
	output logic [13:0] cmp
);
	// ****************
	// Comparators
	// ****************
	// Trip and release pairs; a zero offset means the pin is grounded
	always_comb
	begin
		cmp[0] = vbat_mv >= CV_MV;
		cmp[1] = vbat_mv < RECHG_MV;
		cmp[2] = vbat_mv < PRE_MV;
		cmp[3] = iout_ma < TERM_MA;
		cmp[4] = ntc_mv < HOT_MV;
		cmp[5] = ntc_mv < HOT_MV + HYST_MV;
		cmp[6] = ntc_mv > COLD_MV;
		cmp[7] = ntc_mv > COLD_MV - HYST_MV;
		cmp[8] = ntc_mv > cto_mv;
		cmp[9] = ntc_mv > cto_mv - HYST_MV;
		cmp[10] = cto_mv == 0;
		cmp[11] = ntc_mv < DIS_MV;
		cmp[12] = tsel == 0;
		cmp[13] = tsel == 1;
	end
endmodule // battery_pack_model
`default_nettype wire

// file: sim/test_charge_cycle_sequencer.sv
// Purpose: Self-checking bench for the charge cycle sequencer
// Assumes: One second of timer is four clocks
// Notes: Outputs compared as {enable, active_n, fault_n, expired}
`timescale 1ns/1ps
`default_nettype none
module test_charge_cycle_sequencer;
	logic clock, arst_n, ce;
	int vbat, iout, ntc, cold_threshold_offset, tsel, fail_count, n_tests;
	logic [15:0] prog;
	logic [13:0] c;
	logic oe, act_n, flt_n, expd;
	battery_pack_model u_battery_pack_model (.vbat_mv(vbat), .iout_ma(iout),
		.ntc_mv(ntc), .cto_mv(cold_threshold_offset), .tsel(tsel), .cmp(c));
	charge_cycle_sequencer #(.TICK_CYCLES(4)) u_charge_cycle_sequencer (
		.CLOCK(clock), .ARST_N(arst_n), .CE(ce), .VBAT_AT_CV(c[0]),
		.VBAT_BELOW_RECHARGE(c[1]), .VBAT_BELOW_PRECHARGE(c[2]),
		.IOUT_BELOW_TERM(c[3]), .NTC_BELOW_HOT_TRIP(c[4]),
		.NTC_BELOW_HOT_RELEASE(c[5]), .NTC_ABOVE_COLD_DEF_TRIP(c[6]),
		.NTC_ABOVE_COLD_DEF_RELEASE(c[7]), .NTC_ABOVE_COLD_CTO_TRIP(c[8]),
		.NTC_ABOVE_COLD_CTO_RELEASE(c[9]), .COLD_OFFSET_GROUNDED(c[10]),
		.NTC_BELOW_DISABLE(c[11]), .TIMER_SELECT_HIGH(c[12]),
		.TIMER_SELECT_GROUNDED(c[13]), .TIMER_PROG_MINUTES(prog),
		.OUTPUT_ENABLE(oe), .CHARGE_ACTIVE_FLAG_N(act_n),
		.FAULT_FLAG_N(flt_n), .TIMER_EXPIRED(expd));
	// ****************
	// Helpers
	// ****************
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Samples just after the edge, then returns on the next edge
	task automatic chk(input logic [3:0] want, input logic [3:0] care);
		#1;
		n_tests++;
		if (({oe, act_n, flt_n, expd} & care) !== want)
		begin
			fail_count++;
			$display("CHECK FAILED outputs expected %b seen %b", want,
				{oe, act_n, flt_n, expd});
		end
		@(posedge clock);
	endtask
	task automatic final_report;
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	initial
	begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// Tests need some 42000 clocks; a hang is cut at 60000
	initial
	begin
		#480000;
		fail_count++;
		final_report();
	end
	initial
	begin
		{arst_n, ce, vbat, iout, ntc, cold_threshold_offset, tsel, prog} = {1'b0, 1'b1,
			32'd3500, 32'd500, 32'd2500, 32'd0, 32'd1, 16'h0078};
		fail_count = 0;
		n_tests = 0;
		tick(5);
		arst_n <= 1;
		chk(4'h6, 4'hf);
		tick(8);
		chk(4'ha, 4'hf);
		vbat <= 4200;
		tick(8);
		chk(4'ha, 4'hf);
		iout <= 50;
		tick(8);
		chk(4'h6, 4'hf);
		vbat <= 4000;
		iout <= 500;
		tick(12);
		chk(4'ha, 4'hf);
		ntc <= 1400;
		tick(8);
		chk(4'h0, 4'hb);
		ntc <= 1550;
		tick(8);
		chk(4'h0, 4'hb);
		ntc <= 2500;
		tick(8);
		chk(4'ha, 4'hf);
		cold_threshold_offset <= 3000;
		ntc <= 3100;
		tick(8);
		chk(4'h0, 4'hb);
		cold_threshold_offset <= 0;
		tick(8);
		chk(4'ha, 4'hf);
		ntc <= 3800;
		tick(8);
		chk(4'h0, 4'hb);
		ntc <= 500;
		tick(8);
		chk(4'h6, 4'hf);
		// Programmed 120 minutes is 28800 clocks of on-time
		{tsel, vbat, iout, ntc} <= {32'd2, 32'd4200, 32'd50, 32'd2500};
		tick(20);
		chk(4'he, 4'hf);
		ntc <= 1400;
		tick(2000);
		ntc <= 2500;
		tick(28500);
		chk(4'he, 4'hf);
		tick(500);
		chk(4'h7, 4'hf);
		// Default 180 minutes: precharge may last 10800 clocks
		ntc <= 500;
		tick(8);
		{tsel, vbat, iout, ntc} <= {32'd0, 32'd2500, 32'd500, 32'd2500};
		tick(10700);
		chk(4'h8, 4'h9);
		tick(200);
		chk(4'h0, 4'hb);
		vbat <= 3500;
		tick(10);
		chk(4'ha, 4'hf);
		// Enable low freezes the block; the pause lands once it returns
		ce <= 0;
		ntc <= 1400;
		tick(20);
		chk(4'ha, 4'hf);
		ce <= 1;
		tick(8);
		chk(4'h0, 4'hb);
		final_report();
	end
endmodule // test_charge_cycle_sequencer
`default_nettype wire
